// ==== meter_command_telegram.sv ====
// command telegram engine of the energy meter process image
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "meter_cmd_defines.svh"

// What this block does
// - byte 1 holds command code 01, 03, 04, 06 or 07
// - clear status takes four mask bytes and echoes them back
// - meter write data: measurand id 3..8, overflow byte, four-byte value
// - code 01 clears all energy counters, ignores data, answers no data
// - code 04 answers ten version bytes, request data ignored
// - answer byte 0 is type 100, bit 7 zero, low nibble comm status
// - answer byte 1 echoes the received command code
// - answer byte 2 upper nibble is the returned data length
// - answer byte 3 is common status; request byte 3 disregarded
// - multi-byte user data follow the configured byte order, save protocol version and chip date, always sent high byte first
// - reduced variant implements neither holding read nor meter write
// - version reply: bytes 2..0 firmware, 5..3 protocol, 9..6 chip date
module meter_command_telegram #(
  parameter bit FULL_CMDS = 1'b1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  // process image port
  input wire logic [`MC_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // configuration and measurement core
  input wire logic bigEndian,
  input wire logic [7:0] commonStatus,
  input wire logic [23:0] fwVersion,
  input wire logic [23:0] protoVersion,
  input wire logic [31:0] chipDate,
  input wire logic [31:0] holdData,
  output logic clearCounters,
  output logic clearStatus,
  output logic [31:0] statusMask,
  output logic holdRead,
  output logic meterWrite,
  output logic [7:0] meterId,
  output logic [7:0] meterOverflow,
  output logic [31:0] meterValue,
  output logic [3:0] datasetIndex
);

  // request and answer images
  meter_cmd_pkg::byte_t req_q [`MC_IMAGE_BYTES];
  meter_cmd_pkg::byte_t rsp_q [`MC_IMAGE_BYTES];
  meter_cmd_pkg::byte_t rsp_d [`MC_IMAGE_BYTES];
  meter_cmd_pkg::eng_state_e state_q;
  meter_cmd_pkg::eng_state_e state_d;
  logic submit;
  logic execNow;
  logic rspSeq_q;
  logic [7:0] rdData_q;
  logic [7:0] rdNext;
  logic [3:0] commStat;
  logic actOk;
  logic typeOk;
  logic idOk;
  logic [31:0] reqWord0;
  logic [31:0] reqWord2;
  logic [31:0] fwWord;
  logic [31:0] holdWord;
  logic [3:0] reqDsi;
  logic isClrCnt;
  logic isClrStat;
  logic isHold;
  logic isMeter;

  cmd_decode_if dec ();

  cmd_decode #(
    .FULL_CMDS(FULL_CMDS)
  ) u_decode (
    .dec(dec)
  );

  // reorder four bytes into a word by byte order
  function automatic logic [31:0] pack4(
    input logic [7:0] a,
    input logic [7:0] b,
    input logic [7:0] c,
    input logic [7:0] d,
    input logic big
  );
    pack4 = big ? {a, b, c, d} : {d, c, b, a};
  endfunction

  // byte k of a word as it goes out, by byte order
  function automatic logic [7:0] wordByte(
    input logic [31:0] w,
    input logic [1:0] k,
    input logic big
  );
    logic [1:0] sel;
    // the cast keeps the reversed index at two bits
    sel = big ? 2'(2'h3 - k) : k;
    wordByte = w[8*sel +: 8];
  endfunction

  // request writes; writing header byte 0 submits the telegram
  // byte 0 goes last, so the rest of the telegram already stands when it runs
  assign submit = regWrite && (regAddr == `MC_OFS_IMAGE);

  // request image, kept per byte
  genvar gi;
  generate
    for (gi = 0; gi < `MC_IMAGE_BYTES; gi++) begin : g_req
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          req_q[gi] <= `MC_RESET_BYTE;
        end else if (regWrite && regAddr == 5'(gi)) begin
          req_q[gi] <= regWrData;
        end
      end
    end
  endgenerate

  // engine state: one execute cycle per submitted telegram
  // a submit during execute runs once more with the newer bytes
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      meter_cmd_pkg::ST_IDLE: begin
        if (submit) begin
          state_d = meter_cmd_pkg::ST_EXEC;
        end
      end
      meter_cmd_pkg::ST_EXEC: begin
        state_d = submit ? meter_cmd_pkg::ST_EXEC : meter_cmd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q <= meter_cmd_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign execNow = (state_q == meter_cmd_pkg::ST_EXEC);

  // decoder feed
  // command code taken from byte 1
  assign dec.cmdCode = req_q[1];
  assign dec.reqLen = req_q[2][`MC_LEN_MSB:`MC_LEN_LSB];

  assign reqDsi = req_q[2][`MC_DSI_MSB:`MC_DSI_LSB];

  // only type 100 counts, error nibble unread
  assign typeOk = (req_q[0][`MC_TYPE_MSB:`MC_TYPE_LSB] == `MC_TYPE_CMD);

  // user data words in configured order
  assign reqWord0 = pack4(req_q[4], req_q[5], req_q[6], req_q[7], bigEndian);
  assign reqWord2 = pack4(req_q[6], req_q[7], req_q[8], req_q[9], bigEndian);
  assign fwWord = {8'h00, fwVersion};
  assign holdWord = holdData;

  // measurand id must lie in 3..8
  assign idOk = (req_q[4] >= `MC_METER_ID_MIN) && (req_q[4] <= `MC_METER_ID_MAX);

  // communication status in priority order
  // a wrong telegram type outranks all else, so foreign telegrams never act
  always_comb begin
    if (!typeOk) begin
      commStat = `MC_ST_BAD_TYPE;
    end else if (!dec.codeKnown) begin
      commStat = `MC_ST_BAD_CODE;
    end else if (!dec.lenOk) begin
      commStat = `MC_ST_BAD_LEN;
    end else if (dec.kind == meter_cmd_pkg::CK_METER && !idOk) begin
      commStat = `MC_ST_BAD_ARG;
    end else begin
      commStat = `MC_ST_OK;
    end
  end

  assign actOk = execNow && (commStat == `MC_ST_OK);

  // one decoded kind per accepted telegram
  assign isClrCnt = actOk && (dec.kind == meter_cmd_pkg::CK_CLR_CNT);
  assign isClrStat = actOk && (dec.kind == meter_cmd_pkg::CK_CLR_STAT);
  assign isHold = actOk && (dec.kind == meter_cmd_pkg::CK_HOLD);
  assign isMeter = actOk && (dec.kind == meter_cmd_pkg::CK_METER);

  // answer image built from the decoded command
  always_comb begin
    for (int i = 0; i < `MC_IMAGE_BYTES; i++) begin
      rsp_d[i] = `MC_RESET_BYTE;
    end
    // type 100, bit 7 clear, status nibble
    rsp_d[0] = {1'b0, `MC_TYPE_CMD, commStat};
    rsp_d[1] = req_q[1];
    rsp_d[2] = {(commStat == `MC_ST_OK) ? dec.rspLen : `MC_LEN_NONE, reqDsi};
    rsp_d[3] = commonStatus;
    if (commStat == `MC_ST_OK) begin
      unique case (dec.kind)
        meter_cmd_pkg::CK_CLR_STAT: begin
          for (int i = 4; i < 8; i++) begin
            rsp_d[i] = req_q[i];
          end
        end
        meter_cmd_pkg::CK_VERSION: begin
          for (int i = 0; i < 3; i++) begin
            // three bytes of a four-byte word: the empty top byte is skipped in both orders
            rsp_d[4+i] = wordByte(fwWord, bigEndian ? 2'(i + 1) : 2'(i), bigEndian);
          end
          rsp_d[7] = protoVersion[23:16];
          rsp_d[8] = protoVersion[15:8];
          rsp_d[9] = protoVersion[7:0];
          rsp_d[10] = chipDate[31:24];
          rsp_d[11] = chipDate[23:16];
          rsp_d[12] = chipDate[15:8];
          rsp_d[13] = chipDate[7:0];
        end
        meter_cmd_pkg::CK_HOLD: begin
          for (int i = 0; i < 4; i++) begin
            rsp_d[4+i] = wordByte(holdWord, 2'(i), bigEndian);
          end
        end
        meter_cmd_pkg::CK_METER: begin
          for (int i = 4; i < 10; i++) begin
            rsp_d[i] = req_q[i];
          end
        end
        default: begin
          rsp_d[4] = `MC_RESET_BYTE;
        end
      endcase
    end
  end

  // answer image updates in the execute cycle
  // the toggle tells software that a fresh answer stands
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      for (int i = 0; i < `MC_IMAGE_BYTES; i++) begin
        rsp_q[i] <= `MC_RESET_BYTE;
      end
      rspSeq_q <= 1'b0;
    end else if (execNow) begin
      for (int i = 0; i < `MC_IMAGE_BYTES; i++) begin
        rsp_q[i] <= rsp_d[i];
      end
      rspSeq_q <= ~rspSeq_q;
    end
  end

  // action pulses toward the measurement core
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      clearCounters <= 1'b0;
      clearStatus <= 1'b0;
      holdRead <= 1'b0;
      meterWrite <= 1'b0;
    end else begin
      clearCounters <= isClrCnt;
      clearStatus <= isClrStat;
      holdRead <= isHold;
      meterWrite <= isMeter;
    end
  end

  // dataset index of the last accepted command
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      datasetIndex <= 4'h0;
    end else if (actOk) begin
      datasetIndex <= reqDsi;
    end
  end

  // status mask held beside its pulse
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      statusMask <= `MC_RESET_WORD;
    end else if (isClrStat) begin
      statusMask <= reqWord0;
    end
  end

  // meter arguments taken as integer bits
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      meterId <= `MC_RESET_BYTE;
      meterOverflow <= `MC_RESET_BYTE;
      meterValue <= `MC_RESET_WORD;
    end else if (isMeter) begin
      meterId <= req_q[4];
      meterOverflow <= req_q[5];
      meterValue <= reqWord2;
    end
  end

  // read mux: answer image, engine status, else zero
  // the image index drops bit 4, safe since only 0x00..0x0f reach it
  always_comb begin
    rdNext = `MC_RESET_BYTE;
    if (regAddr <= `MC_OFS_IMAGE_LAST) begin
      rdNext = rsp_q[regAddr[3:0]];
    end else if (regAddr == `MC_OFS_STATUS) begin
      rdNext = {6'h00, rspSeq_q, execNow};
    end
  end

  // read data stand one cycle after the strobe only
  // zero outside the answer cycle, so a stale byte never looks like data
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rdData_q <= `MC_RESET_BYTE;
    end else begin
      rdData_q <= regRead ? rdNext : `MC_RESET_BYTE;
    end
  end

  assign regRdData = rdData_q;

endmodule // meter_command_telegram
`default_nettype wire

// ==== meter_cmd_defines.svh ====
// offsets, field positions, codes and reset values of the command telegram block
`ifndef METER_CMD_DEFINES_SVH
`define METER_CMD_DEFINES_SVH

// register map, one byte per address
`define MC_ADDR_W 5
`define MC_OFS_IMAGE 5'h00
`define MC_OFS_IMAGE_LAST 5'h0f
`define MC_OFS_STATUS 5'h10
`define MC_IMAGE_BYTES 16
`define MC_HDR_BYTES 4
`define MC_DATA_BYTES 12

// header byte 0 fields
`define MC_TYPE_MSB 6
`define MC_TYPE_LSB 4
`define MC_TYPE_CMD 3'h4
`define MC_RSV_BIT 7
// header byte 2 fields
`define MC_LEN_MSB 7
`define MC_LEN_LSB 4
`define MC_DSI_MSB 3
`define MC_DSI_LSB 0

// command codes
`define MC_CODE_CLR_CNT 8'h01
`define MC_CODE_CLR_STAT 8'h03
`define MC_CODE_VERSION 8'h04
`define MC_CODE_HOLD 8'h06
`define MC_CODE_METER 8'h07

// user data lengths in bytes
`define MC_LEN_NONE 4'h0
`define MC_LEN_STAT 4'h4
`define MC_LEN_HOLD 4'h4
`define MC_LEN_METER 4'h6
`define MC_LEN_VERSION 4'ha

// measurand identifiers accepted by the meter write
`define MC_METER_ID_MIN 8'h03
`define MC_METER_ID_MAX 8'h08

// communication status codes
`define MC_ST_OK 4'h0
`define MC_ST_BAD_CODE 4'h1
`define MC_ST_BAD_LEN 4'h2
`define MC_ST_BAD_ARG 4'h3
`define MC_ST_BAD_TYPE 4'h4

// reset values
`define MC_RESET_BYTE 8'h00
`define MC_RESET_WORD 32'h0000_0000

`endif

// ==== meter_cmd_pkg.sv ====
// types shared by the command telegram modules
`default_nettype none
package meter_cmd_pkg;

  // command kinds after decoding
  typedef enum logic [2:0] {
    CK_NONE = 3'b000,
    CK_CLR_CNT = 3'b001,
    CK_CLR_STAT = 3'b010,
    CK_VERSION = 3'b011,
    CK_HOLD = 3'b100,
    CK_METER = 3'b101
  } cmd_kind_e;

  // telegram engine states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } eng_state_e;

  typedef logic [7:0] byte_t;

endpackage
`default_nettype wire

// ==== cmd_decode_if.sv ====
// carries a command code to the decoder and its verdict back
`timescale 1ns/100ps
`default_nettype none
interface cmd_decode_if;
  logic [7:0] cmdCode;
  logic [3:0] reqLen;
  logic codeKnown;
  logic lenOk;
  logic [3:0] rspLen;
  meter_cmd_pkg::cmd_kind_e kind;

  modport engine (output cmdCode, output reqLen, input codeKnown, input lenOk, input rspLen, input kind);
  modport decoder (input cmdCode, input reqLen, output codeKnown, output lenOk, output rspLen, output kind);
endinterface
`default_nettype wire

// ==== cmd_decode.sv ====
// command code decoder: kind, expected request length, answer length
`timescale 1ns/100ps
`default_nettype none
`include "meter_cmd_defines.svh"
module cmd_decode #(
  parameter bit FULL_CMDS = 1'b1
) (
  cmd_decode_if.decoder dec
);

  logic [3:0] expLen;

  // map code to kind, lengths follow from it
  always_comb begin
    dec.kind = meter_cmd_pkg::CK_NONE;
    expLen = `MC_LEN_NONE;
    dec.rspLen = `MC_LEN_NONE;
    unique case (dec.cmdCode)
      `MC_CODE_CLR_CNT: begin
        dec.kind = meter_cmd_pkg::CK_CLR_CNT;
      end
      `MC_CODE_CLR_STAT: begin
        dec.kind = meter_cmd_pkg::CK_CLR_STAT;
        expLen = `MC_LEN_STAT;
        dec.rspLen = `MC_LEN_STAT;
      end
      `MC_CODE_VERSION: begin
        dec.kind = meter_cmd_pkg::CK_VERSION;
        dec.rspLen = `MC_LEN_VERSION;
      end
      `MC_CODE_HOLD: begin
        if (FULL_CMDS) begin
          dec.kind = meter_cmd_pkg::CK_HOLD;
          dec.rspLen = `MC_LEN_HOLD;
        end
      end
      `MC_CODE_METER: begin
        if (FULL_CMDS) begin
          dec.kind = meter_cmd_pkg::CK_METER;
          expLen = `MC_LEN_METER;
          dec.rspLen = `MC_LEN_METER;
        end
      end
      default: begin
        dec.kind = meter_cmd_pkg::CK_NONE;
      end
    endcase
  end

  assign dec.codeKnown = (dec.kind != meter_cmd_pkg::CK_NONE);
  assign dec.lenOk = (dec.reqLen == expLen);

endmodule // cmd_decode
`default_nettype wire

// ==== meter_core_model.sv ====
// measurement core model beside the telegram block
`timescale 1ns/100ps
`default_nettype none
module meter_core_model (
  input wire logic clk_sys,
  input wire logic clearCounters,
  output logic [7:0] commonStatus,
  output logic [23:0] fwVersion,
  output logic [23:0] protoVersion,
  output logic [31:0] chipDate,
  output logic [31:0] holdData,
  output int clrCount
);
  assign commonStatus = 8'h5a;
  assign fwVersion = 24'h112233;
  assign protoVersion = 24'h010203;
  assign chipDate = 32'h1c0a1407;
  assign holdData = 32'hcafe0042;
  initial clrCount = 0;
  always @(posedge clk_sys) begin
    if (clearCounters) clrCount <= clrCount + 1;
  end
endmodule // meter_core_model
`default_nettype wire

// ==== meter_command_telegram_properties.sv ====
// port checks of the command telegram block
`timescale 1ns/100ps
`default_nettype none
`include "meter_cmd_defines.svh"
module meter_command_telegram_properties #(
  parameter bit FULL_CMDS = 1'b1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [`MC_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic clearCounters,
  input wire logic clearStatus,
  input wire logic [31:0] statusMask,
  input wire logic holdRead,
  input wire logic meterWrite,
  input wire logic [7:0] meterId,
  input wire logic [31:0] meterValue
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire logic anyPulse;
  assign anyPulse = clearCounters | clearStatus | holdRead | meterWrite;
  // no command submit on byte 0
  sequence s_no_submit;
    !(regWrite && regAddr == 5'h00 && regWrData[6:4] == 3'h4);
  endsequence
  // action two cycles after a cycle without submit
  sequence s_late_pulse;
    s_no_submit ##2 anyPulse;
  endsequence
  a_pulse_cause: assert property (not s_late_pulse) else $error("pulse without submit");
  a_clr_once: assert property (clearCounters && !$past(regWrite) |=> !clearCounters) else $error("long clear");
  a_pulse_excl: assert property ($onehot0({clearCounters, clearStatus, holdRead, meterWrite})) else $error("two pulses");
  a_meter_range: assert property (meterWrite |-> meterId >= 8'h03 && meterId <= 8'h08) else $error("bad id");
  a_reduced_none: assert property (!FULL_CMDS |-> !holdRead && !meterWrite) else $error("reduced action");
  a_mask_change: assert property ($changed(statusMask) |-> clearStatus) else $error("mask moved");
  a_value_change: assert property ($changed(meterValue) |-> meterWrite) else $error("value moved");
  a_rd_idle: assert property (!$past(regRead) |-> regRdData == 8'h00) else $error("read data stands");
  a_rd_unmapped: assert property ($past(regRead) && $past(regAddr) > 5'h10 |-> regRdData == 8'h00) else $error("unmapped");
endmodule // meter_command_telegram_properties
bind meter_command_telegram meter_command_telegram_properties #(.FULL_CMDS(FULL_CMDS)) props_inst (
  .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
  .regRead(regRead), .regRdData(regRdData), .clearCounters(clearCounters), .clearStatus(clearStatus),
  .statusMask(statusMask), .holdRead(holdRead), .meterWrite(meterWrite), .meterId(meterId),
  .meterValue(meterValue)
);
`default_nettype wire

// ==== meter_command_telegram_bench.sv ====
// self-checking bench of the command telegram block
`timescale 1ns/100ps
`default_nettype none
module meter_command_telegram_bench;
  logic clk_sys, reset_n, regWrite, regRead, bigEndian;
  logic [4:0] regAddr;
  logic [7:0] regWrData;
  wire logic [7:0] regRdData, commonStatus, meterId, meterOverflow;
  wire logic [23:0] fwVersion, protoVersion;
  wire logic [31:0] chipDate, holdData, statusMask, meterValue;
  wire logic clearCounters, clearStatus, holdRead, meterWrite;
  wire logic [3:0] datasetIndex;
  int clrCount, error_cnt = 0, n_tests = 0, cyc = 0;
  logic [7:0] d[12];
  logic [7:0] fb0[4] = '{8'h40, 8'h40, 8'h40, 8'h20};
  logic [7:0] fcode[4] = '{8'h02, 8'h03, 8'h07, 8'h01};
  logic [7:0] fb2[4] = '{8'h00, 8'h00, 8'h60, 8'h00};
  logic [7:0] fst[4] = '{8'h41, 8'h42, 8'h43, 8'h44};
  meter_command_telegram #(.FULL_CMDS(1'b1)) meter_command_telegram_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .bigEndian(bigEndian), .commonStatus(commonStatus),
    .fwVersion(fwVersion), .protoVersion(protoVersion), .chipDate(chipDate), .holdData(holdData),
    .clearCounters(clearCounters), .clearStatus(clearStatus), .statusMask(statusMask), .holdRead(holdRead),
    .meterWrite(meterWrite), .meterId(meterId), .meterOverflow(meterOverflow), .meterValue(meterValue),
    .datasetIndex(datasetIndex)
  );
  meter_core_model meter_core_model_inst (
    .clk_sys(clk_sys), .clearCounters(clearCounters), .commonStatus(commonStatus), .fwVersion(fwVersion),
    .protoVersion(protoVersion), .chipDate(chipDate), .holdData(holdData), .clrCount(clrCount)
  );
  // clock and cycle ceiling
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      results();
    end
  end
  task automatic results;
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regRead <= 1'b0;
    regAddr <= a;
    regWrData <= v;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    regWrite <= 1'b0;
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 chk({24'h0, regRdData}, {24'h0, e});
  endtask
  // data bytes, header, byte 0 last; returns in the pulse cycle
  task automatic send(input logic [7:0] b0, input logic [7:0] code, input logic [7:0] b2, input int n);
    for (int i = 0; i < n; i++) wr(5'h04 + 5'(i), d[i]);
    wr(5'h01, code);
    wr(5'h02, b2);
    wr(5'h03, 8'ha5);
    wr(5'h00, b0);
    @(posedge clk_sys);
    regWrite <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic hdr(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    rd(5'h00, b0);
    rd(5'h01, b1);
    rd(5'h02, b2);
    rd(5'h03, 8'h5a);
  endtask
  task automatic pay(input int n);
    for (int i = 0; i < n; i++) rd(5'h04 + 5'(i), d[i]);
  endtask
  // main sequence
  initial begin
    {regWrite, regRead, regAddr, regWrData} = '0;
    bigEndian = 1'b1;
    reset_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(5'h00, 8'h00);
    rd(5'h11, 8'h00);
    d = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    send(8'h4f, 8'h03, 8'h43, 4);
    chk({clearCounters, clearStatus, holdRead, meterWrite}, 4'b0100);
    chk(statusMask, 32'h12345678);
    hdr(8'h40, 8'h03, 8'h43);
    pay(4);
    rd(5'h10, 8'h02);
    @(posedge clk_sys);
    bigEndian <= 1'b0;
    send(8'h40, 8'h03, 8'h43, 4);
    chk(statusMask, 32'h78563412);
    send(8'h40, 8'h01, 8'h07, 0);
    chk({clearCounters, clearStatus, holdRead, meterWrite}, 4'b1000);
    chk(datasetIndex, 4'h7);
    #20 chk(clrCount, 1);
    hdr(8'h40, 8'h01, 8'h07);
    send(8'h40, 8'h04, 8'h00, 0);
    hdr(8'h40, 8'h04, 8'ha0);
    d = '{8'h33, 8'h22, 8'h11, 8'h01, 8'h02, 8'h03, 8'h1c, 8'h0a, 8'h14, 8'h07, 8'h00, 8'h00};
    pay(10);
    @(posedge clk_sys);
    bigEndian <= 1'b1;
    send(8'h40, 8'h06, 8'h00, 0);
    chk({clearCounters, clearStatus, holdRead, meterWrite}, 4'b0010);
    hdr(8'h40, 8'h06, 8'h40);
    d = '{8'hca, 8'hfe, 8'h00, 8'h42, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    pay(4);
    d = '{8'h05, 8'h09, 8'hde, 8'had, 8'hbe, 8'hef, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    send(8'h40, 8'h07, 8'h62, 6);
    chk({clearCounters, clearStatus, holdRead, meterWrite}, 4'b0001);
    chk({meterId, meterOverflow}, 16'h0509);
    chk(meterValue, 32'hdeadbeef);
    hdr(8'h40, 8'h07, 8'h62);
    pay(6);
    d[0] = 8'h09;
    for (int k = 0; k < 4; k++) begin
      send(fb0[k], fcode[k], fb2[k], 6);
      chk({clearCounters, clearStatus, holdRead, meterWrite}, 4'b0000);
      rd(5'h00, fst[k]);
      rd(5'h01, fcode[k]);
      rd(5'h02, 8'h00);
    end
    chk({meterId, meterValue}, 40'h05deadbeef);
    results();
  end
endmodule // meter_command_telegram_bench
`default_nettype wire
